// >>> logic/prhg_pkg.sv
// shared constants and types of the physical rng health gate
// assumes a clocked digitiser feeding one raw bit per valid beat
package prhg_pkg;

	// ---------------------------------------------------------------
	// output word and buffering
	// ---------------------------------------------------------------
	localparam int unsigned PRHG_WORD_W     = 8;
	localparam int unsigned PRHG_FIFO_DEPTH = 16;
	localparam logic [2:0]  PRHG_BIT_LAST   = 3'h7;

	// ---------------------------------------------------------------
	// statistical online test: ones count over a fixed window
	// ---------------------------------------------------------------
	localparam logic [7:0]  PRHG_WIN_LAST   = 8'hFF;   // window of 256 bits
	localparam logic [8:0]  PRHG_ONES_MIN   = 9'h060;  // 96 ones lowest tolerable
	localparam logic [8:0]  PRHG_ONES_MAX   = 9'h0A0;  // 160 ones highest tolerable

	// ---------------------------------------------------------------
	// total failure test: run of identical bits
	// ---------------------------------------------------------------
	localparam logic [5:0]  PRHG_STUCK_LIMIT = 6'h20;  // 32 equal bits count as dead

	// entropy bound per bit, in thousandths (quality target of the source)
	localparam int unsigned PRHG_ENTROPY_PERMILLE = 997;

	// ---------------------------------------------------------------
	// gate states and status carrier
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PRHG_ST_START = 2'b00,
		PRHG_ST_RUN   = 2'b01,
		PRHG_ST_FAIL  = 2'b10
	} prhg_state_type;

	typedef struct packed {
		logic pending;
		logic valid;
		logic fail_total;
		logic fail_stat;
	} prhg_status_type;

endpackage

// >>> logic/prhg_top.sv
// health gate of the physical rng with its output fifo
// assumes digitiser and consumer run on clk_i; reset synchronous active high
`timescale 1ns/1ps

// ---------------------------------------------------------------
// word fifo between assembler and consumer
// ---------------------------------------------------------------
module prhg_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	// discard all contents
	input  wire logic             flush_i,
	// fill side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output wire logic             in_ready_o,
	// drain side
	output wire logic             out_valid_o,
	output wire logic [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW-1:0] PTR_ONE = AW'(1);
	localparam logic [AW:0]   CNT_ONE = (AW+1)'(1);
	localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	wire  logic       push;
	wire  logic       pop;

	// handshakes and occupancy
	assign in_ready_o  = (cnt_q != CNT_FULL);
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// next occupancy
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + CNT_ONE;
		end else if (pop && !push) begin
			cnt_d = cnt_q - CNT_ONE;
		end
	end

	// pointers and count
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || flush_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + PTR_ONE;
			if (pop) rd_q <= rd_q + PTR_ONE;
			cnt_q <= cnt_d;
		end
	end

	// storage, data only
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
endmodule

// ---------------------------------------------------------------
// health gate top
// ---------------------------------------------------------------
module prhg_top
	import prhg_pkg::*;
(
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	// digitised noise output of the entropy source
	input  wire logic                   raw_bit_i,
	input  wire logic                   raw_valid_i,
	output wire logic                   raw_ready_o,
	// random words to the processor
	output wire logic [PRHG_WORD_W-1:0] rnd_data_o,
	output wire logic                   rnd_valid_o,
	input  wire logic                   rnd_ready_i,
	// rerun the start-up test
	input  wire logic                   restart_i,
	// gate status
	output wire prhg_status_type        status_o
);
	prhg_state_type   state_q;
	prhg_state_type   state_d;
	logic             last_bit_q;
	logic [5:0]       run_cnt_q;
	logic [5:0]       run_cnt_d;
	logic [7:0]       win_cnt_q;
	logic [8:0]       ones_q;
	logic             fail_total_q;
	logic             fail_stat_q;
	logic [6:0]       shift_q;
	logic [2:0]       bit_idx_q;

	wire  logic                   bit_take;
	wire  logic                   same_bit;
	wire  logic                   stuck_hit;
	wire  logic                   win_end;
	wire  logic [8:0]             ones_final;
	wire  logic                   stat_bad;
	wire  logic                   stat_pass;
	wire  logic                   fail_now;
	wire  logic                   in_run;
	wire  logic                   word_done;
	wire  logic                   push_word;
	wire  logic [PRHG_WORD_W-1:0] word;
	wire  logic                   fifo_in_ready;
	wire  logic                   fifo_out_valid;
	wire  logic                   fifo_flush;

	// ---------------------------------------------------------------
	// raw bit intake
	// ---------------------------------------------------------------
	assign in_run    = (state_q == PRHG_ST_RUN);
	assign word_done = in_run && (bit_idx_q == PRHG_BIT_LAST);
	// stall the source only when a finished word has nowhere to go
	assign raw_ready_o = !(word_done && !fifo_in_ready);
	assign bit_take    = raw_valid_i & raw_ready_o;

	// ---------------------------------------------------------------
	// total failure test: run length of equal bits
	// ---------------------------------------------------------------
	assign same_bit  = (run_cnt_q != 6'h00) && (raw_bit_i == last_bit_q);
	assign stuck_hit = bit_take && same_bit && (run_cnt_q == PRHG_STUCK_LIMIT - 6'h01);

	// saturating run counter
	assign run_cnt_d = !same_bit ? 6'h01 :
		(run_cnt_q == PRHG_STUCK_LIMIT) ? run_cnt_q : run_cnt_q + 6'h01;

	// ---------------------------------------------------------------
	// statistical online test: ones per window
	// ---------------------------------------------------------------
	assign win_end    = bit_take && (win_cnt_q == PRHG_WIN_LAST);
	assign ones_final = ones_q + {8'h00, raw_bit_i};
	assign stat_bad   = win_end && ((ones_final < PRHG_ONES_MIN) || (ones_final > PRHG_ONES_MAX));
	assign stat_pass  = win_end && !stat_bad;
	assign fail_now   = stuck_hit || stat_bad;

	// ---------------------------------------------------------------
	// gate state: failure beats restart, pass opens output
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			PRHG_ST_START: begin
				if (fail_now) begin
					state_d = PRHG_ST_FAIL;
				end else if (restart_i) begin
					state_d = PRHG_ST_START;
				end else if (stat_pass) begin
					state_d = PRHG_ST_RUN;
				end
			end
			PRHG_ST_RUN: begin
				if (fail_now) begin
					state_d = PRHG_ST_FAIL;
				end else if (restart_i) begin
					state_d = PRHG_ST_START;
				end
			end
			PRHG_ST_FAIL: begin
				if (restart_i && !fail_now) begin
					state_d = PRHG_ST_START;
				end
			end
			default: begin
				state_d = PRHG_ST_FAIL;
			end
		endcase
	end

	// state and sticky failure flags, set wins over restart
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q      <= PRHG_ST_START;
			fail_total_q <= 1'b0;
			fail_stat_q  <= 1'b0;
		end else begin
			state_q      <= state_d;
			fail_total_q <= (fail_total_q & !restart_i) | stuck_hit;
			fail_stat_q  <= (fail_stat_q & !restart_i) | stat_bad;
		end
	end

	// test counters run on every accepted bit, in every state
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || restart_i) begin
			last_bit_q <= 1'b0;
			run_cnt_q  <= 6'h00;
			win_cnt_q  <= 8'h00;
			ones_q     <= 9'h000;
		end else if (bit_take) begin
			last_bit_q <= raw_bit_i;
			run_cnt_q  <= run_cnt_d;
			win_cnt_q  <= win_cnt_q + 8'h01;
			ones_q     <= win_end ? 9'h000 : ones_final;
		end
	end

	// ---------------------------------------------------------------
	// word assembly of raw bits, no conditioning
	// ---------------------------------------------------------------
	assign word      = {shift_q, raw_bit_i};
	assign push_word = bit_take && word_done && !fail_now;

	// shift register restarts whenever the gate is not open
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !in_run || fail_now) begin
			shift_q   <= 7'h00;
			bit_idx_q <= 3'h0;
		end else if (bit_take) begin
			shift_q   <= word[6:0];
			bit_idx_q <= bit_idx_q + 3'h1;
		end
	end

	// ---------------------------------------------------------------
	// output buffer, emptied when the gate closes
	// ---------------------------------------------------------------
	assign fifo_flush = !in_run || fail_now;

	prhg_fifo #(
		.WIDTH (PRHG_WORD_W),
		.DEPTH (PRHG_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.flush_i     (fifo_flush),
		.in_valid_i  (push_word),
		.in_data_i   (word),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (fifo_out_valid),
		.out_data_o  (rnd_data_o),
		.out_ready_i (rnd_ready_i)
	);

	// delivery only while the gate is open
	assign rnd_valid_o = fifo_out_valid && in_run && !fail_now;

	// status view for the processor
	assign status_o.pending    = (state_q == PRHG_ST_START);
	assign status_o.valid      = in_run;
	assign status_o.fail_total = fail_total_q;
	assign status_o.fail_stat  = fail_stat_q;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	no_out_closed_a: assert property (!in_run |-> !rnd_valid_o)
		else $error("random word offered while gate closed");

	stuck_fails_a: assert property (stuck_hit |=> state_q == PRHG_ST_FAIL && fail_total_q)
		else $error("stuck source did not close the gate");

	stuck_blocks_a: assert property (stuck_hit |=> !fifo_out_valid [*2])
		else $error("words left after total failure");

	stat_fails_a: assert property (stat_bad |=> state_q == PRHG_ST_FAIL && fail_stat_q)
		else $error("statistical defect did not close the gate");

	fail_holds_a: assert property (state_q == PRHG_ST_FAIL && !restart_i |=> state_q == PRHG_ST_FAIL)
		else $error("gate reopened without restart");

	pass_opens_a: assert property (state_q == PRHG_ST_START && stat_pass && !stuck_hit
		&& !restart_i |=> in_run)
		else $error("passing start-up window did not open gate");

	start_needs_pass_a: assert property (state_q == PRHG_ST_START && !stat_pass
		|=> state_q != PRHG_ST_RUN)
		else $error("gate opened without a passing window");

	window_wrap_a: assert property (win_end && !restart_i |=> win_cnt_q == 8'h00
		&& ones_q == 9'h000)
		else $error("online test window did not restart");

	window_step_a: assert property (bit_take && !restart_i && !win_end
		|=> win_cnt_q == $past(win_cnt_q) + 8'h01)
		else $error("online test missed an accepted bit");

	raw_direct_a: assert property (bit_take && in_run && !fail_now && !word_done
		|=> shift_q[0] == $past(raw_bit_i))
		else $error("raw bit altered on its way to output");

	status_one_a: assert property ($onehot({status_o.pending, status_o.valid,
		state_q == PRHG_ST_FAIL}))
		else $error("status shows more than one gate state");

	run_bound_a: assert property (run_cnt_q <= PRHG_STUCK_LIMIT)
		else $error("run counter beyond limit");

	// main scenarios
	gate_opens_c: cover property (state_q == PRHG_ST_START ##1 in_run);
	word_out_c: cover property (rnd_valid_o && rnd_ready_i);
	stuck_run_c: cover property (in_run && stuck_hit);
	defect_run_c: cover property (in_run && stat_bad);
	backpress_c: cover property (raw_valid_i && !raw_ready_o);

endmodule

// >>> dv/prhg_consumer.sv
// consumer model of the random words, far side of the gate
// assumes one clock with the gate; stall and slow come from the bench
`timescale 1ns/1ps
module prhg_consumer (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// word handshake
	input  wire logic valid_i,
	output logic      ready_o,
	// pacing commands
	input  wire logic stall_i,
	input  wire logic slow_i
);
	logic [1:0] ph_q;

	// ready every cycle, every fourth when slow, never when stalled
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ph_q    <= 2'h0;
			ready_o <= 1'b0;
		end else begin
			ph_q    <= ph_q + 2'h1;
			ready_o <= !stall_i && (!slow_i || ph_q == 2'h0);
		end
	end
endmodule

// >>> dv/prhg_top_tb.sv
// self-checking bench of the rng health gate
// assumes prhg_pkg, prhg_top and prhg_consumer compiled first
`timescale 1ns/1ps
module prhg_top_tb
	import prhg_pkg::*;
;
	logic                   clk_i, sys_rst_i, raw_bit_i, raw_valid_i, restart_i;
	logic                   raw_ready_o, rnd_valid_o, rnd_ready_i, stall, slow, run;
	logic [PRHG_WORD_W-1:0] rnd_data_o, wrd, ev;
	prhg_status_type        status_o;
	logic [7:0]             exp_q[$];
	int                     n_errors = 0, cmp_count = 0, nb = 0, seed = 85;

	prhg_top prhg_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .raw_bit_i(raw_bit_i),
		.raw_valid_i(raw_valid_i), .raw_ready_o(raw_ready_o), .rnd_data_o(rnd_data_o),
		.rnd_valid_o(rnd_valid_o), .rnd_ready_i(rnd_ready_i), .restart_i(restart_i),
		.status_o(status_o));
	prhg_consumer prhg_consumer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.valid_i(rnd_valid_o), .ready_o(rnd_ready_i), .stall_i(stall), .slow_i(slow));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// offer one raw bit until taken; words of bits taken in run are noted
	task automatic send_bit(input logic b);
		logic tk;
		tk = 1'b0;
		raw_bit_i   <= b;
		raw_valid_i <= 1'b1;
		while (tk !== 1'b1) begin
			@(negedge clk_i);
			tk  = raw_ready_o;
			run = status_o.valid;
			@(posedge clk_i);
		end
		if (run === 1'b1) begin
			wrd = {wrd[6:0], b};
			nb++;
			if (nb == 8) begin
				exp_q.push_back(wrd);
				nb = 0;
			end
		end else begin
			nb = 0;
		end
	endtask

	// patterns: 0 alternating, 1 random, 2 ones, 3 sparse ones, 4 zeros
	task automatic feed(input int mode, input int n);
		logic b;
		b = 1'b0;
		for (int i = 0; i < n; i++) begin
			case (mode)
				0: b = i[0];
				1: b = 1'($random(seed));
				2: b = 1'b1;
				3: b = (i[3:0] == 4'h0);
				default: b = 1'b0;
			endcase
			send_bit(b);
		end
		raw_valid_i <= 1'b0;
		raw_bit_i   <= ~b;
		@(posedge clk_i);
	endtask

	task automatic chk_st(input logic [7:0] e);
		@(negedge clk_i);
		check("status", {4'h0, status_o}, e);
		@(posedge clk_i);
	endtask

	task automatic restart();
		restart_i <= 1'b1;
		@(posedge clk_i);
		restart_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// ---------------------------------------------------------------
	// clock, monitor, watchdog
	// ---------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// every word taken is compared with the oldest note
	always @(negedge clk_i) begin
		if (rnd_valid_o === 1'b1) begin
			check("gate open", {7'h0, status_o.valid}, 8'h01);
			if (rnd_ready_i === 1'b1) begin
				ev = (exp_q.size() > 0) ? exp_q.pop_front() : ~rnd_data_o;
				check("word", rnd_data_o, ev);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		$display("ERROR watchdog expected end seen hang");
		test_done();
	end

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		sys_rst_i   = 1'b1;
		raw_bit_i   = 1'b0;
		raw_valid_i = 1'b0;
		restart_i   = 1'b0;
		stall       = 1'b0;
		slow        = 1'b0;
		wrd         = 8'h00;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		chk_st(8'h08);
		feed(0, 256);
		chk_st(8'h04);
		$display("test startup done");
		// fill the fifo with consumer stalled, then drain slowly
		stall <= 1'b1;
		feed(1, 135);
		raw_bit_i   <= 1'b1;
		raw_valid_i <= 1'b1;
		@(negedge clk_i);
		check("raw ready full", {7'h0, raw_ready_o}, 8'h00);
		@(posedge clk_i);
		stall <= 1'b0;
		slow  <= 1'b1;
		send_bit(1'b1);
		feed(1, 64);
		for (int k = 0; k < 800 && exp_q.size() > 0; k++) @(posedge clk_i);
		@(negedge clk_i);
		check("drained", {7'h0, rnd_valid_o}, 8'h00);
		check("notes left", 8'(exp_q.size()), 8'h00);
		@(posedge clk_i);
		$display("test stream done");
		// stuck source while running, held words must vanish
		stall <= 1'b1;
		slow  <= 1'b0;
		feed(2, 32);
		@(posedge clk_i);
		chk_st(8'h02);
		exp_q.delete();
		nb = 0;
		stall <= 1'b0;
		repeat (20) @(posedge clk_i);
		$display("test stuck run done");
		restart();
		chk_st(8'h08);
		feed(4, 40);
		chk_st(8'h02);
		$display("test stuck start done");
		restart();
		feed(3, 256);
		chk_st(8'h01);
		restart();
		feed(0, 256);
		chk_st(8'h04);
		// restart while open with words held, gate must fall back to start-up
		stall <= 1'b1;
		feed(1, 16);
		restart();
		chk_st(8'h08);
		exp_q.delete();
		stall <= 1'b0;
		feed(0, 256);
		chk_st(8'h04);
		$display("test restart done");
		feed(3, 256);
		chk_st(8'h01);
		exp_q.delete();
		repeat (10) @(posedge clk_i);
		$display("test defect done");
		test_done();
	end
endmodule
